// [inc/temp_sensor_map.svh]
// Offsets, field positions, reset values and timing counts of the sensor core.
// Assumes a 10 MHz core clock; included by the core and its filter.
`ifndef TEMP_SENSOR_MAP_SVH
`define TEMP_SENSOR_MAP_SVH

// Core clock rate and cycles per millisecond
`define CLK_HZ            10000000
`define CYCLES_PER_MS     (`CLK_HZ / 1000)

// Register pointers
`define PTR_TEMP          8'h00
`define PTR_CONFIG        8'h01
`define PTR_CTRL_STATUS   8'h04

// Field positions
`define CFG_SHUTDOWN_BIT  7
`define CFG_ONESHOT_BIT   2
`define CS_RES_HI_BIT     6
`define CS_RES_LO_BIT     5
`define CS_DAV_BIT        0

// Reset and one-shot values
`define TEMP_RESET        16'h7ffc
`define TEMP_ONESHOT      16'h8000
`define RES_RESET         2'h0
`define DAV_RESET         1'b0

// Result masks per resolution: 11, 12, 13, 14 bits
`define MASK_RES11        16'hffe0
`define MASK_RES12        16'hfff0
`define MASK_RES13        16'hfff8
`define MASK_RES14        16'hfffc

// Upper four bits of the slave address
`define ADDR_UPPER        4'h9

// Stuck-bus timeout window in ms, centre taken as the working value
`define TIMEOUT_MIN_MS    15
`define TIMEOUT_MAX_MS    45
`define TIMEOUT_CYCLES    (((`TIMEOUT_MIN_MS + `TIMEOUT_MAX_MS) / 2) * `CYCLES_PER_MS)

// Conversion times in ms per resolution
`define CONV11_MS         14
`define CONV12_MS         28
`define CONV13_MS         56
`define CONV14_MS         112
`define CONV11_CYCLES     (`CONV11_MS * `CYCLES_PER_MS)
`define CONV12_CYCLES     (`CONV12_MS * `CYCLES_PER_MS)
`define CONV13_CYCLES     (`CONV13_MS * `CYCLES_PER_MS)
`define CONV14_CYCLES     (`CONV14_MS * `CYCLES_PER_MS)

// Consecutive agreeing samples before a filtered line changes
`define FILTER_LEN        2

`endif

// [inc/temp_sensor_pkg.sv]
// Types shared by the sensor core.
// Assumes nothing beyond a SystemVerilog compiler.
package temp_sensor_pkg;

   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_PTR    = 3'b010,
      ST_WDATA  = 3'b011,
      ST_RDATA  = 3'b100,
      ST_ACK_TX = 3'b101,
      ST_ACK_RX = 3'b110
   } bus_state_t;

   // Resolution field: 0 = 11 bits ... 3 = 14 bits
   typedef logic [1:0] resolution_t;

endpackage

// [logic/glitch_filter.sv]
// Two-flop synchroniser followed by a consecutive-sample glitch filter.
// Assumes the line idles high, as a pulled-up bus line does.
`timescale 1ns/1ps
`include "temp_sensor_map.svh"

module glitch_filter #(
   parameter int unsigned LEN = `FILTER_LEN
) (
   input  wire logic clk,      // Core clock
   input  wire logic reset_n,  // Asynchronous reset, active low
   input  wire logic pin,      // Raw line from the pad
   output logic      level     // Filtered, synchronised level
);

   logic       sync1;
   logic       sync2;
   logic [3:0] cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser: the first flop feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Level follows only after LEN disagreeing samples in a row
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level <= 1'b1;
         cnt   <= 4'h0;
      end else if (sync2 == level) begin
         cnt <= 4'h0;
      end else if (cnt == 4'(LEN - 1)) begin
         level <= sync2;
         cnt   <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // A change of level needs a full run of agreeing samples
   a_filter_run: assert property (
      @(posedge clk) disable iff (!reset_n)
      (level != $past(level)) |-> ($past(cnt) == 4'(LEN - 1) && $past(sync2) == level))
      else $error("filtered level changed without a full sample run");

endmodule

// [logic/temp_sensor_smbus_slave_core.sv]
// Digital core of a die temperature sensor with a two-wire slave port.
// Assumes the converter word arrives on clk; bus pins come from the pads.
`timescale 1ns/1ps
`include "temp_sensor_map.svh"

module temp_sensor_smbus_slave_core #(
   parameter logic        VERSION        = 1'b0,              // Address group, 0 or 1
   parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES,   // Stuck-bus timeout
   parameter int unsigned CONV11_CYCLES  = `CONV11_CYCLES,    // 11-bit conversion
   parameter int unsigned CONV12_CYCLES  = `CONV12_CYCLES,    // 12-bit conversion
   parameter int unsigned CONV13_CYCLES  = `CONV13_CYCLES,    // 13-bit conversion
   parameter int unsigned CONV14_CYCLES  = `CONV14_CYCLES     // 14-bit conversion
) (
   input  wire logic        clk,         // Core clock, 10 MHz
   input  wire logic        reset_n,     // Power-on reset, active low
   input  wire logic        scl_in,      // Bus clock pin, input only
   input  wire logic        sda_in,      // Bus data pin, input side
   output logic             sda_out,     // Bus data pin, output value (always 0)
   output logic             sda_oe_n,    // Bus data drive enable, low drives
   input  wire logic [1:0]  addr_pin,    // Address pin: 0 float, 1 ground, 2 supply
   input  wire logic [13:0] adc_result,  // Converter word, 0.03125 degree step
   output logic             converting   // High while a conversion runs
);

   logic                      scl_f;
   logic                      sda_f;
   logic                      scl_d;
   logic                      sda_d;
   logic [1:0]                addr_meta;
   logic [1:0]                addr_sync;
   logic [23:0]               low_cnt;
   temp_sensor_pkg::bus_state_t state;
   temp_sensor_pkg::bus_state_t ack_next;
   logic [3:0]                bit_cnt;
   logic [7:0]                shift;
   logic [7:0]                tx;
   logic [7:0]                pointer;
   logic                      rd_idx;
   logic                      nack;
   logic                      reg_wr_en;
   logic                      shutdown;
   logic                      oneshot_req;
   temp_sensor_pkg::resolution_t resolution;
   temp_sensor_pkg::resolution_t conv_res;
   logic [23:0]               conv_cnt;
   logic [15:0]               temperature_result;
   logic                      conversion_done_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Line filters; the engine never sees the raw pins
   glitch_filter u_scl_filter (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (scl_in),
      .level   (scl_f)
   );

   glitch_filter u_sda_filter (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (sda_in),
      .level   (sda_f)
   );

   // Delayed copies for edge, start and stop detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise   = scl_f & ~scl_d;
   assign scl_fall   = ~scl_f & scl_d;
   assign start_cond = scl_f & scl_d & sda_d & ~sda_f;
   assign stop_cond  = scl_f & scl_d & ~sda_d & sda_f;

   ////////////////////////////////////////////////////////////////////////////
   // Address strap through two flops; unused code 3 reads as float
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_meta <= 2'h0;
         addr_sync <= 2'h0;
      end else begin
         addr_meta <= addr_pin;
         addr_sync <= addr_meta;
      end
   end

   logic [6:0] my_addr;
   assign my_addr = {`ADDR_UPPER, VERSION, (addr_sync == 2'h3) ? 2'h0 : addr_sync};

   ////////////////////////////////////////////////////////////////////////////
   // Stuck-bus timer; saturates so the engine stays parked while low
   logic bus_low;
   logic timeout_hit;
   assign bus_low     = ~scl_f | ~sda_f;
   assign timeout_hit = bus_low && (low_cnt == 24'(TIMEOUT_CYCLES - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt <= 24'h0;
      end else if (!bus_low) begin
         low_cnt <= 24'h0;
      end else if (!timeout_hit) begin
         low_cnt <= low_cnt + 24'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read bytes and the acknowledge decision for the byte just taken
   logic [7:0] cfg_byte;
   logic [7:0] cs_byte;
   logic [7:0] tx_byte;
   logic       byte_ok;
   temp_sensor_pkg::bus_state_t ack_target;

   always_comb begin
      cfg_byte = 8'h00;
      cfg_byte[`CFG_SHUTDOWN_BIT] = shutdown;
      cs_byte = 8'h00;
      cs_byte[`CS_RES_HI_BIT] = resolution[1];
      cs_byte[`CS_RES_LO_BIT] = resolution[0];
      cs_byte[`CS_DAV_BIT] = conversion_done_flag;
      unique case (pointer)
         `PTR_TEMP:        tx_byte = rd_idx ? temperature_result[7:0] : temperature_result[15:8];
         `PTR_CONFIG:      tx_byte = cfg_byte;
         `PTR_CTRL_STATUS: tx_byte = cs_byte;
         default:          tx_byte = 8'h00;
      endcase
   end

   always_comb begin
      byte_ok    = 1'b1;
      ack_target = temp_sensor_pkg::ST_WDATA;
      if (state == temp_sensor_pkg::ST_ADDR) begin
         byte_ok    = (shift[7:1] == my_addr);
         ack_target = shift[0] ? temp_sensor_pkg::ST_RDATA : temp_sensor_pkg::ST_PTR;
      end else if (state == temp_sensor_pkg::ST_PTR) begin
         byte_ok = (shift == `PTR_TEMP) || (shift == `PTR_CONFIG)
                   || (shift == `PTR_CTRL_STATUS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial engine; data only ever pulled low, clock never touched
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= temp_sensor_pkg::ST_IDLE;
         ack_next  <= temp_sensor_pkg::ST_IDLE;
         bit_cnt   <= 4'h0;
         shift     <= 8'h00;
         tx        <= 8'h00;
         pointer   <= `PTR_TEMP;
         rd_idx    <= 1'b0;
         nack      <= 1'b0;
         reg_wr_en <= 1'b0;
         sda_out   <= 1'b0;
         sda_oe_n  <= 1'b1;
      end else begin
         reg_wr_en <= 1'b0;
         if (timeout_hit || stop_cond) begin
            state    <= temp_sensor_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
         end else if (start_cond) begin
            // Repeated start is accepted from any state
            state    <= temp_sensor_pkg::ST_ADDR;
            bit_cnt  <= 4'h0;
            rd_idx   <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            if (state == temp_sensor_pkg::ST_ADDR || state == temp_sensor_pkg::ST_PTR
                || state == temp_sensor_pkg::ST_WDATA) begin
               shift   <= {shift[6:0], sda_f};
               bit_cnt <= bit_cnt + 4'h1;
            end
            if (state == temp_sensor_pkg::ST_ACK_RX) begin
               nack <= sda_f;
            end
         end else if (scl_fall) begin
            unique case (state)
               temp_sensor_pkg::ST_IDLE: begin
               end
               temp_sensor_pkg::ST_ADDR, temp_sensor_pkg::ST_PTR,
               temp_sensor_pkg::ST_WDATA: begin
                  if (bit_cnt == 4'h8) begin
                     bit_cnt <= 4'h0;
                     if (byte_ok) begin
                        sda_oe_n <= 1'b0;
                        state    <= temp_sensor_pkg::ST_ACK_TX;
                        ack_next <= ack_target;
                        if (state == temp_sensor_pkg::ST_PTR) begin
                           pointer <= shift;
                        end
                        reg_wr_en <= (state == temp_sensor_pkg::ST_WDATA);
                     end else begin
                        // Unmatched address or bad pointer: no acknowledge
                        state <= temp_sensor_pkg::ST_IDLE;
                     end
                  end
               end
               temp_sensor_pkg::ST_ACK_TX, temp_sensor_pkg::ST_ACK_RX: begin
                  if ((state == temp_sensor_pkg::ST_ACK_RX && nack)
                      || (state == temp_sensor_pkg::ST_ACK_TX
                          && ack_next != temp_sensor_pkg::ST_RDATA)) begin
                     sda_oe_n <= 1'b1;
                     state    <= (state == temp_sensor_pkg::ST_ACK_RX)
                                 ? temp_sensor_pkg::ST_IDLE : ack_next;
                  end else begin
                     // Drive the first bit of the next read byte
                     sda_oe_n <= tx_byte[7];
                     tx       <= {tx_byte[6:0], 1'b0};
                     rd_idx   <= ~rd_idx;
                     bit_cnt  <= 4'h0;
                     state    <= temp_sensor_pkg::ST_RDATA;
                  end
               end
               temp_sensor_pkg::ST_RDATA: begin
                  if (bit_cnt == 4'h7) begin
                     sda_oe_n <= 1'b1;
                     bit_cnt  <= 4'h0;
                     state    <= temp_sensor_pkg::ST_ACK_RX;
                  end else begin
                     sda_oe_n <= tx[7];
                     tx       <= {tx[6:0], 1'b0};
                     bit_cnt  <= bit_cnt + 4'h1;
                  end
               end
               default: begin
                  state    <= temp_sensor_pkg::ST_IDLE;
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer; a shutdown request lets the running one finish
   logic conv_done;
   logic conv_start;
   logic [23:0] conv_len;
   assign conv_done  = converting && (conv_cnt == 24'h0);
   assign conv_start = (!converting || conv_done) && (!shutdown || oneshot_req);

   always_comb begin
      unique case (resolution)
         2'h0: conv_len = 24'(CONV11_CYCLES - 1);
         2'h1: conv_len = 24'(CONV12_CYCLES - 1);
         2'h2: conv_len = 24'(CONV13_CYCLES - 1);
         2'h3: conv_len = 24'(CONV14_CYCLES - 1);
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         converting <= 1'b0;
         conv_cnt   <= 24'h0;
         conv_res   <= `RES_RESET;
      end else if (conv_start) begin
         converting <= 1'b1;
         conv_cnt   <= conv_len;
         conv_res   <= resolution;
      end else if (conv_done) begin
         converting <= 1'b0;
      end else if (converting) begin
         conv_cnt <= conv_cnt - 24'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result formatting: left justified, unused low bits forced to zero
   logic [15:0] res_mask;
   logic [15:0] fmt_result;
   always_comb begin
      unique case (conv_res)
         2'h0: res_mask = `MASK_RES11;
         2'h1: res_mask = `MASK_RES12;
         2'h2: res_mask = `MASK_RES13;
         2'h3: res_mask = `MASK_RES14;
      endcase
      fmt_result = {adc_result, 2'b00} & res_mask;
   end

   // Result and done flag; a one-shot start parks the result at its marker
   logic oneshot_start;
   assign oneshot_start = conv_start && shutdown;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         temperature_result   <= `TEMP_RESET;
         conversion_done_flag <= `DAV_RESET;
      end else if (oneshot_start) begin
         temperature_result   <= `TEMP_ONESHOT;
         conversion_done_flag <= 1'b0;
      end else if (conv_done) begin
         temperature_result   <= fmt_result;
         conversion_done_flag <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable bits; only a master write changes them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shutdown   <= 1'b0;
         resolution <= `RES_RESET;
      end else if (reg_wr_en && pointer == `PTR_CONFIG) begin
         shutdown <= shift[`CFG_SHUTDOWN_BIT];
      end else if (reg_wr_en && pointer == `PTR_CTRL_STATUS) begin
         resolution <= {shift[`CS_RES_HI_BIT], shift[`CS_RES_LO_BIT]};
      end
   end

   // One-shot request; a new write wins over the clear by a start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oneshot_req <= 1'b0;
      end else if (reg_wr_en && pointer == `PTR_CONFIG && shift[`CFG_ONESHOT_BIT]
                   && shift[`CFG_SHUTDOWN_BIT]) begin
         oneshot_req <= 1'b1;
      end else if (conv_start) begin
         oneshot_req <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_idle_released: assert property (
      (state == temp_sensor_pkg::ST_IDLE && $past(state) == temp_sensor_pkg::ST_IDLE)
      |-> (sda_oe_n && !sda_out))
      else $error("data line driven while idle");

   a_addr_reject: assert property (
      (state == temp_sensor_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && !start_cond
       && !stop_cond && !timeout_hit && shift[7:1] != my_addr)
      |=> (state == temp_sensor_pkg::ST_IDLE && sda_oe_n))
      else $error("foreign address acknowledged");

   a_timeout_idle: assert property (
      timeout_hit |=> (state == temp_sensor_pkg::ST_IDLE && sda_oe_n))
      else $error("timeout left the engine active");

   a_timeout_count: assert property (
      (low_cnt != 24'h0) |-> ($past(bus_low) && low_cnt <= 24'(TIMEOUT_CYCLES - 1)))
      else $error("timeout counter out of step with the lines");

   a_oneshot_state: assert property (
      (oneshot_start && !reg_wr_en) |=> (converting && !conversion_done_flag
      && temperature_result == `TEMP_ONESHOT) [*2])
      else $error("one-shot state not entered");

   a_conv_result: assert property (
      (conv_done && !oneshot_start) |=> (conversion_done_flag
      && temperature_result == $past(fmt_result) && (temperature_result & ~$past(res_mask)) == 16'h0))
      else $error("result not loaded or low bits not cleared");

   a_shutdown_stops: assert property (
      (shutdown && !oneshot_req && !converting && !reg_wr_en) |=> !converting)
      else $error("conversion started in shutdown");

   a_back_to_back: assert property (
      (conv_done && !shutdown) |=> (converting && conv_cnt == $past(conv_len)))
      else $error("continuous conversion not restarted");

   a_oneshot_once: assert property (
      (reg_wr_en && pointer == `PTR_CONFIG && shift[`CFG_ONESHOT_BIT]
       && shift[`CFG_SHUTDOWN_BIT]) |=> oneshot_req)
      else $error("one-shot write lost");

   c_oneshot: cover property (oneshot_start ##1 (converting && !conversion_done_flag));
   c_timeout: cover property (timeout_hit);
   c_read_ack: cover property (state == temp_sensor_pkg::ST_ACK_RX && scl_fall && !nack);
   c_res14: cover property (conv_done && conv_res == 2'h3);

endmodule

// [tb/smbus_host_model.sv]
// Two-wire host model: drives the bus clock and open-drain data.
// Assumes the core clock paces every phase, eight core cycles a bit.
`timescale 1ns/1ps
module smbus_host_model (
   input  wire logic clk,       // Core clock
   input  wire logic sda_wire,  // Resolved data line
   output logic      scl,       // Bus clock, idles high
   output logic      sda_drv    // Host data, 1 releases
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // Low 600 ns, high 200 ns; data moves 200 ns after the fall
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      repeat (2) @(posedge clk);
      sda_drv <= b;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      @(posedge clk);
      r = sda_wire;
      @(posedge clk);
   endtask
   // Start (1,0) or stop (0,1) while the clock is high
   task automatic edge_cond(input logic a, input logic b);
      int n;
      scl <= 1'b0;
      repeat (2) @(posedge clk);
      sda_drv <= a;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      for (n = 0; n < 400 && a && sda_wire !== 1'b1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      sda_drv <= b;
      repeat (14) @(posedge clk);
   endtask
   task automatic byte_out(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
      bit_io(1'b1, ack);
   endtask
   task automatic byte_in(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(mack, r);
   endtask
   // Stalls the bus with the clock held low
   task automatic hold_low(input int n);
      scl <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
endmodule

// [tb/temp_sensor_smbus_slave_core_tb_top.sv]
// Self-checking bench for the sensor core against a host model.
// Assumes shortened timeout and conversion counts set below.
`timescale 1ns/1ps
module temp_sensor_smbus_slave_core_tb_top;
   logic        clk, reset_n, sda_out, sda_oe_n, converting, scl, sda_drv, sda_wire, a;
   logic [1:0]  addr_pin;
   logic [13:0] adc_result;
   logic [15:0] v;
   int          fails, checked, i, r;
   int          seed = 32'h308e;
   // Shortened counts, shared by the overrides and the waits
   localparam int TO_CYCLES = 200;
   localparam int C11 = 20, C12 = 30, C13 = 40, C14 = 1000;
   int          conv [4] = '{C11, C12, C13, C14};
   // Open drain: either party pulls low, else pulled up
   assign sda_wire = sda_drv & (sda_oe_n | sda_out);
   temp_sensor_smbus_slave_core #(.TIMEOUT_CYCLES(TO_CYCLES), .CONV11_CYCLES(C11),
      .CONV12_CYCLES(C12), .CONV13_CYCLES(C13), .CONV14_CYCLES(C14)) dut_u (
      .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .addr_pin(addr_pin), .adc_result(adc_result),
      .converting(converting));
   smbus_host_model host_u (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done();
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Expected word: left justified, bits below resolution cleared
   function automatic logic [15:0] exp_t(input int adc, input int res);
      return 16'((adc << 2) & (32'hffff << (5 - res)));
   endfunction
   // Pointer byte, then an optional data byte
   task automatic reg_wr(input logic [7:0] p, input logic [7:0] d, input logic wd);
      host_u.edge_cond(1'b1, 1'b0);
      host_u.byte_out(8'h92, a);
      host_u.byte_out(p, a);
      if (wd) host_u.byte_out(d, a);
      host_u.edge_cond(1'b0, 1'b1);
   endtask
   task automatic rd16(output logic [15:0] x);
      host_u.edge_cond(1'b1, 1'b0);
      host_u.byte_out(8'h93, a);
      host_u.byte_in(1'b0, x[15:8]);
      host_u.byte_in(1'b1, x[7:0]);
      host_u.edge_cond(1'b0, 1'b1);
   endtask
   // Bounded wait; conversion counts can hang a broken design
   task automatic wait_idle();
      for (int n = 0; n < 3000 && converting !== 1'b0; n++) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      test_done();
   end
   initial begin
      reset_n = 1'b0;
      addr_pin = 2'h1;
      adc_result = 14'h0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_wr(8'h04, 8'h00, 1'b0);
      rd16(v);
      chk("resolution", {14'h0, v[6:5]}, 16'h0);
      // Every strap level against every address; strap code 3 reads as float
      for (i = 0; i < 4; i++) begin
         addr_pin <= 2'(i);
         repeat (4) @(posedge clk);
         for (r = 0; r < 3; r++) begin
            host_u.edge_cond(1'b1, 1'b0);
            host_u.byte_out({4'h9, 3'(r), 1'b0}, a);
            host_u.edge_cond(1'b0, 1'b1);
            chk("address ack", {15'h0, a}, {15'h0, (i % 3) != r});
         end
      end
      addr_pin <= 2'h1;
      // Each resolution, results refreshed with no trigger
      for (r = 0; r < 4; r++) begin
         adc_result <= 14'($random(seed));
         reg_wr(8'h04, {1'b0, 2'(r), 5'h0}, 1'b1);
         repeat (2 * conv[r] + 10) @(posedge clk);
         reg_wr(8'h00, 8'h00, 1'b0);
         rd16(v);
         chk("temperature", v, exp_t(adc_result, r));
      end
      adc_result <= 14'($random(seed)) & 14'h1fff;
      reg_wr(8'h01, 8'h80, 1'b1);
      chk("converting", {15'h0, converting}, 16'h1);
      wait_idle();
      reg_wr(8'h00, 8'h00, 1'b0);
      rd16(v);
      chk("temperature", v, exp_t(adc_result, 3));
      // Single shot from shutdown
      adc_result <= 14'($random(seed)) & 14'h1fff;
      reg_wr(8'h01, 8'h84, 1'b1);
      chk("converting", {15'h0, converting}, 16'h1);
      reg_wr(8'h04, 8'h00, 1'b0);
      rd16(v);
      chk("done flag", {15'h0, v[0]}, 16'h0);
      reg_wr(8'h00, 8'h00, 1'b0);
      rd16(v);
      chk("temperature", v, 16'h8000);
      wait_idle();
      rd16(v);
      chk("temperature", v, exp_t(adc_result, 3));
      repeat (1100) @(posedge clk);
      chk("converting", {15'h0, converting}, 16'h0);
      reg_wr(8'h04, 8'h00, 1'b0);
      rd16(v);
      chk("done flag", {15'h0, v[0]}, 16'h1);
      // Stall a read while the core drives a zero top bit
      host_u.edge_cond(1'b1, 1'b0);
      host_u.byte_out(8'h93, a);
      host_u.hold_low(20);
      chk("data drive", {15'h0, sda_oe_n}, 16'h0);
      host_u.hold_low(230);
      chk("data drive", {15'h0, sda_oe_n}, 16'h1);
      host_u.edge_cond(1'b0, 1'b1);
      host_u.edge_cond(1'b1, 1'b0);
      host_u.byte_out(8'h92, a);
      host_u.edge_cond(1'b0, 1'b1);
      chk("address ack", {15'h0, a}, 16'h0);
      // Reset in mid-run: the shutdown bit returns to its reset value
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("converting", {15'h0, converting}, 16'h1);
      reg_wr(8'h01, 8'h00, 1'b0);
      rd16(v);
      chk("configuration", v, 16'h0000);
      test_done();
   end
endmodule
